// [design/mfc_domain_sel.sv]
// Selects one two-bit domain field from the packed domain access word.
// Purely combinational; the word comes from the register in the top module.
`timescale 1ns/1ps
module mfc_domain_sel (
  // Packed fields and selector
  input wire logic [31:0] dac,
  input wire logic [3:0] dom,
  // Selected field
  output logic [1:0] field
);
  import mfc_pkg::*;
  logic [1:0] fields [NUM_DOMAINS];
  for (genvar n = 0; n < NUM_DOMAINS; n++) begin : g_dom
    assign fields[n] = dac[2*n+1:2*n];
  end
  assign field = fields[dom];
endmodule

// [design/mfc_perm_check.sv]
// Access-permission decode for one two-bit permission field.
// Assumes the caller has already selected the field for the access.
`timescale 1ns/1ps
module mfc_perm_check (
  // Field and mode
  input wire logic [1:0] ap,
  input wire logic rdonly,
  input wire logic user,
  input wire logic write,
  // Verdict
  output logic allowed
);
  import mfc_pkg::*;
  always_comb begin
    case (ap)
      2'h0: allowed = rdonly && !user && !write;
      2'h1: allowed = !user;
      2'h2: allowed = !user || !write;
      default: allowed = 1'b1;
    endcase
  end
endmodule

// [design/mfc_pkg.sv]
// Constants for the MMU fault checker: register map, control bits, fault codes, bus classes.
// Shared by the top module and both leaf modules.
package mfc_pkg;
  localparam logic [7:0] OFF_DOMAIN_ACCESS = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_FAULT_STATUS = 8'h08;
  localparam logic [7:0] OFF_FAULT_ADDRESS = 8'h0c;
  localparam logic [31:0] DAC_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_MMU_EN_BIT = 0;
  localparam int CTRL_ALIGN_BIT = 1;
  localparam int CTRL_RDONLY_BIT = 8;
  localparam int FSR_NONREC_BIT = 8;
  localparam int DESC_DOM_LSB = 5;
  localparam int SEC_AP_LSB = 10;
  localparam int SUBPAGE_AP_LSB = 4;
  localparam int NUM_DOMAINS = 16;
  localparam int SMALL_QTR_LSB = 10;
  localparam int LARGE_QTR_LSB = 14;
  localparam logic [1:0] L1_SECTION = 2'h2;
  localparam logic [1:0] L1_PAGE_TABLE = 2'h1;
  localparam logic [1:0] L2_LARGE = 2'h1;
  localparam logic [1:0] L2_SMALL = 2'h2;
  localparam logic [1:0] DOM_NO_ACCESS = 2'h0;
  localparam logic [1:0] DOM_CLIENT = 2'h1;
  localparam logic [1:0] DOM_RESERVED = 2'h2;
  localparam logic [1:0] DOM_MANAGER = 2'h3;
  localparam logic [3:0] FS_WRITE_BUF = 4'h0;
  localparam logic [3:0] FS_FILL_SEC = 4'h4;
  localparam logic [3:0] FS_FILL_PAGE = 4'h6;
  localparam logic [3:0] FS_BUS_SEC = 4'h8;
  localparam logic [3:0] FS_BUS_PAGE = 4'ha;
  localparam logic [3:0] FS_ALIGN = 4'h1;
  localparam logic [3:0] FS_WALK_L1 = 4'hc;
  localparam logic [3:0] FS_WALK_L2 = 4'he;
  localparam logic [3:0] FS_TRANS_SEC = 4'h5;
  localparam logic [3:0] FS_TRANS_PAGE = 4'h7;
  localparam logic [3:0] FS_DOM_SEC = 4'h9;
  localparam logic [3:0] FS_DOM_PAGE = 4'hb;
  localparam logic [3:0] FS_PERM_SEC = 4'hd;
  localparam logic [3:0] FS_PERM_PAGE = 4'hf;
  localparam logic [2:0] BUS_UNCACHED_RD = 3'h0;
  localparam logic [2:0] BUS_UNBUF_WR = 3'h1;
  localparam logic [2:0] BUS_L1_FETCH = 3'h2;
  localparam logic [2:0] BUS_L2_FETCH = 3'h3;
  localparam logic [2:0] BUS_LINE_FILL = 3'h4;
  localparam logic [2:0] BUS_BUF_WR = 3'h5;
  typedef enum logic [1:0] {
    MFC_IDLE = 2'b00,
    MFC_WAIT_L1 = 2'b01,
    MFC_WAIT_L2 = 2'b10
  } mfc_state_t;
endpackage

// [design/mfc_top.sv]
// MMU fault checker: alignment, translation, domain and permission checks, fault
// recording and external-abort handling. Assumes a core that offers one access at a time
// and a bus side that reports the class of the external access under way.
//
// Behaviour
// - Each fault source records its own four-bit status code.
// - Undefined status and domain bits read back as zero here.
// - Simultaneous aborts record only the highest-priority source.
// - Section translation fault records bits 8:5 of the invalid entry.
// - Write-buffer bus error is not restartable; address is first aborted operation.
// - Line-fill error domain and address are valid only on word zero.
// - Sixteen two-bit domain fields packed in one 32-bit register.
// - Domain field 00 or 10 raises a section or page domain fault.
// - Client fields are permission-checked; manager fields never are.
// - With alignment check on, unaligned data word accesses fault.
// - Instruction fetches and byte accesses never raise alignment faults.
// - Alignment fault aborts at once, skipping all further checks.
// - Descriptor or page entry type 00 or 11 raises a translation fault.
// - Level-one domain field selects the domain, checked at descriptor return.
// - Permission check runs with the domain check, only for client domains.
// - Section permission uses its bits and the read-only control bit.
// - Pages select one of four sub-page fields by address quarter.
// - Restartable external aborts stop the bus access on the next cycle; here bus_stop rises one cycle after the abort clears the two-flop synchroniser.
// - An aborted locked read cancels the following write.
// - Word-zero fill abort leaves cache untouched; the fill runs to its end.
// - Buffered-write abort is recorded non-recoverable; the burst completes.
// - Permission field: 00 none or privileged read, 01 privileged, 10 user read, 11 all.
// - Prefetch aborts leave fault status and fault address unchanged.
// - Violations are found before the external access starts, which is suppressed.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module mfc_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core access request
  input wire logic acc_req,
  input wire logic [31:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_byte,
  input wire logic acc_instr,
  input wire logic acc_user,
  // Descriptor returns
  input wire logic l1_ready,
  input wire logic [31:0] l1_desc,
  input wire logic l2_ready,
  input wire logic [31:0] l2_desc,
  // Check outcome
  output logic acc_go,
  output logic abort_data,
  output logic abort_prefetch,
  // External bus status
  input wire logic ext_abort,
  input wire logic bus_active,
  input wire logic [2:0] bus_class,
  input wire logic [1:0] bus_word,
  input wire logic bus_page,
  input wire logic bus_locked,
  input wire logic [3:0] bus_domain,
  input wire logic [31:0] bus_vaddr,
  // Bus reactions
  output logic bus_stop,
  output logic lock_write_cancel,
  output logic fill_discard,
  output logic ext_abort_data
);
  import mfc_pkg::*;

  logic [31:0] dac_r;
  logic [31:0] ctrl_r;
  logic [3:0] fs_code_r;
  logic [3:0] fs_dom_r;
  logic fs_nonrec_r;
  logic [31:0] far_r;
  logic [31:0] rdata_r;
  mfc_state_t state_r;
  mfc_state_t state_nxt;
  logic [31:0] addr_r;
  logic write_r, instr_r, user_r;
  logic [3:0] dom_r;
  logic go_r, abort_d_r, abort_p_r;
  logic stop_r, lock_cancel_r, discard_r, ext_data_r;
  logic abort_sync1_r, abort_sync2_r;
  logic [43:0] bus_d1_r, bus_d2_r;

  // Register port.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dac_r <= DAC_RESET;
      ctrl_r <= CTRL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFF_DOMAIN_ACCESS) dac_r <= reg_wdata;
      if (reg_addr == OFF_CONTROL) ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_DOMAIN_ACCESS: rdata_r <= dac_r;
        OFF_CONTROL: rdata_r <= ctrl_r;
        OFF_FAULT_STATUS: rdata_r <= {23'h000000, fs_nonrec_r, fs_dom_r, fs_code_r};
        OFF_FAULT_ADDRESS: rdata_r <= far_r;
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  wire mmu_en = ctrl_r[CTRL_MMU_EN_BIT];
  wire rdonly = ctrl_r[CTRL_RDONLY_BIT];

  // External abort pin passes two flip-flops; bus status is delayed to stay aligned.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      abort_sync1_r <= 1'b0;
      abort_sync2_r <= 1'b0;
      bus_d1_r <= 44'h000_0000_0000;
      bus_d2_r <= 44'h000_0000_0000;
    end else begin
      abort_sync1_r <= ext_abort;
      abort_sync2_r <= abort_sync1_r;
      bus_d1_r <= {bus_active, bus_class, bus_word, bus_page, bus_locked, bus_domain, bus_vaddr};
      bus_d2_r <= bus_d1_r;
    end
  end

  wire b_active = bus_d2_r[43];
  wire [2:0] b_class = bus_d2_r[42:40];
  wire [1:0] b_word = bus_d2_r[39:38];
  wire b_page = bus_d2_r[37];
  wire b_locked = bus_d2_r[36];
  wire [3:0] b_dom = bus_d2_r[35:32];
  wire [31:0] b_vaddr = bus_d2_r[31:0];
  wire ext_evt = abort_sync2_r && b_active;

  wire b_restartable = (b_class == BUS_UNCACHED_RD) || (b_class == BUS_UNBUF_WR) ||
                       (b_class == BUS_L1_FETCH) || (b_class == BUS_L2_FETCH);

  // External abort status code by class.
  logic [3:0] ext_code;
  always_comb begin
    case (b_class)
      BUS_BUF_WR: ext_code = FS_WRITE_BUF;
      BUS_LINE_FILL: ext_code = b_page ? FS_FILL_PAGE : FS_FILL_SEC;
      BUS_L1_FETCH: ext_code = FS_WALK_L1;
      BUS_L2_FETCH: ext_code = FS_WALK_L2;
      default: ext_code = b_page ? FS_BUS_PAGE : FS_BUS_SEC;
    endcase
  end

  // Selected domain and permission verdicts.
  wire l1_sec = (l1_desc[1:0] == L1_SECTION);
  wire l1_pt = (l1_desc[1:0] == L1_PAGE_TABLE);
  wire l2_ok = (l2_desc[1:0] == L2_LARGE) || (l2_desc[1:0] == L2_SMALL);
  wire [3:0] l1_dom = l1_desc[DESC_DOM_LSB+3:DESC_DOM_LSB];
  logic [3:0] dom_sel;
  logic [1:0] dom_field;
  assign dom_sel = (state_r == MFC_WAIT_L2) ? dom_r : l1_dom;

  mfc_domain_sel u_dom (
    .dac(dac_r),
    .dom(dom_sel),
    .field(dom_field)
  );

  wire [1:0] qtr = (l2_desc[1:0] == L2_SMALL) ? addr_r[SMALL_QTR_LSB+1:SMALL_QTR_LSB] :
                   addr_r[LARGE_QTR_LSB+1:LARGE_QTR_LSB];
  wire [1:0] sub_ap = l2_desc[SUBPAGE_AP_LSB + 2*qtr +: 2];
  wire [1:0] perm_ap = (state_r == MFC_WAIT_L2) ? sub_ap : l1_desc[SEC_AP_LSB+1:SEC_AP_LSB];
  logic perm_ok;

  mfc_perm_check u_perm (
    .ap(perm_ap),
    .rdonly(rdonly),
    .user(user_r),
    .write(write_r),
    .allowed(perm_ok)
  );

  wire dom_bad = (dom_field == DOM_NO_ACCESS) || (dom_field == DOM_RESERVED);
  wire perm_bad = (dom_field == DOM_CLIENT) && !perm_ok;

  // no alignment fault on fetch or byte
  wire align_bad = ctrl_r[CTRL_ALIGN_BIT] && !acc_instr && !acc_byte && (acc_addr[1:0] != 2'h0);

  // Fault decision for the current step.
  logic dec_fault, dec_go;
  logic [3:0] dec_code, dec_dom;
  always_comb begin
    dec_fault = 1'b0;
    dec_go = 1'b0;
    dec_code = FS_ALIGN;
    dec_dom = 4'h0;
    state_nxt = state_r;
    case (state_r)
      MFC_IDLE: begin
        if (acc_req) begin
          if (align_bad) begin
            dec_fault = 1'b1;
          end else if (mmu_en) begin
            state_nxt = MFC_WAIT_L1;
          end else begin
            dec_go = 1'b1;
          end
        end
      end
      MFC_WAIT_L1: begin
        if (l1_ready) begin
          dec_dom = l1_dom;
          if (!l1_sec && !l1_pt) begin
            dec_fault = 1'b1;
            dec_code = FS_TRANS_SEC;
            state_nxt = MFC_IDLE;
          end else if (l1_pt) begin
            state_nxt = MFC_WAIT_L2;
          end else if (dom_bad) begin
            dec_fault = 1'b1;
            dec_code = FS_DOM_SEC;
            state_nxt = MFC_IDLE;
          end else if (perm_bad) begin
            dec_fault = 1'b1;
            dec_code = FS_PERM_SEC;
            state_nxt = MFC_IDLE;
          end else begin
            dec_go = 1'b1;
            state_nxt = MFC_IDLE;
          end
        end
      end
      MFC_WAIT_L2: begin
        if (l2_ready) begin
          dec_dom = dom_r;
          state_nxt = MFC_IDLE;
          if (!l2_ok) begin
            dec_fault = 1'b1;
            dec_code = FS_TRANS_PAGE;
          end else if (dom_bad) begin
            dec_fault = 1'b1;
            dec_code = FS_DOM_PAGE;
          end else if (perm_bad) begin
            dec_fault = 1'b1;
            dec_code = FS_PERM_PAGE;
          end else begin
            dec_go = 1'b1;
          end
        end
      end
      default: state_nxt = MFC_IDLE;
    endcase
  end

  wire dec_instr = (state_r == MFC_IDLE) ? acc_instr : instr_r;
  wire [31:0] dec_addr = (state_r == MFC_IDLE) ? acc_addr : addr_r;

  // Sequencer and access context.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= MFC_IDLE;
      addr_r <= 32'h0000_0000;
      write_r <= 1'b0;
      instr_r <= 1'b0;
      user_r <= 1'b0;
      dom_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == MFC_IDLE && acc_req) begin
        addr_r <= acc_addr;
        write_r <= acc_write;
        instr_r <= acc_instr;
        user_r <= acc_user;
      end
      if (state_r == MFC_WAIT_L1 && l1_ready) dom_r <= l1_dom;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      go_r <= 1'b0;
      abort_d_r <= 1'b0;
      abort_p_r <= 1'b0;
    end else begin
      go_r <= dec_go;
      abort_d_r <= dec_fault && !dec_instr;
      abort_p_r <= dec_fault && dec_instr;
    end
  end

  // Fault status and address capture; external aborts outrank MMU faults.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fs_code_r <= 4'h0;
      fs_dom_r <= 4'h0;
      fs_nonrec_r <= 1'b0;
      far_r <= 32'h0000_0000;
    end else if (ext_evt) begin
      fs_code_r <= ext_code;
      fs_dom_r <= (b_class == BUS_BUF_WR || b_class == BUS_L1_FETCH) ? 4'h0 : b_dom;
      // captured even when not word zero
      far_r <= b_vaddr;
      fs_nonrec_r <= (b_class == BUS_BUF_WR);
    end else if (dec_fault && !dec_instr) begin
      fs_code_r <= dec_code;
      fs_dom_r <= dec_dom;
      far_r <= dec_addr;
      fs_nonrec_r <= 1'b0;
    end
  end

  // External abort reactions.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stop_r <= 1'b0;
      lock_cancel_r <= 1'b0;
      discard_r <= 1'b0;
      ext_data_r <= 1'b0;
    end else begin
      stop_r <= ext_evt && b_restartable;
      if (ext_evt && b_locked && b_class == BUS_UNCACHED_RD) lock_cancel_r <= 1'b1;
      else if (!bus_locked) lock_cancel_r <= 1'b0;
      if (ext_evt && b_class == BUS_LINE_FILL && b_word == 2'h0) discard_r <= 1'b1;
      else if (!bus_active) discard_r <= 1'b0;
      ext_data_r <= ext_evt;
    end
  end

  assign reg_rdata = rdata_r;
  assign acc_go = go_r;
  assign abort_data = abort_d_r;
  assign abort_prefetch = abort_p_r;
  assign bus_stop = stop_r;
  assign lock_write_cancel = lock_cancel_r;
  assign fill_discard = discard_r;
  assign ext_abort_data = ext_data_r;

  sequence s_l1_return;
    state_r == MFC_WAIT_L1 && l1_ready;
  endsequence
  sequence s_l2_return;
    state_r == MFC_WAIT_L2 && l2_ready;
  endsequence

  a_align_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == MFC_IDLE && acc_req && align_bad && !acc_instr && !ext_evt
    |=> abort_data && fs_code_r == FS_ALIGN && far_r == $past(acc_addr) && !acc_go)
    else $error("alignment fault not recorded");
  a_align_none_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == MFC_IDLE && acc_req && (acc_instr || acc_byte) && !mmu_en
    |=> acc_go && !abort_data && !abort_prefetch)
    else $error("fetch or byte access faulted without translation");
  a_prefetch_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    abort_prefetch && !$past(ext_evt) |-> $stable(fs_code_r) && $stable(far_r))
    else $error("prefetch abort changed fault registers");
  a_sec_domain: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_l1_return ##0 (l1_sec && dom_bad && !ext_evt && !instr_r)
    |=> abort_data && fs_code_r == FS_DOM_SEC)
    else $error("section domain fault missing");
  a_manager_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_l1_return ##0 (l1_sec && dom_field == DOM_MANAGER) |=> acc_go && !abort_data)
    else $error("manager domain access not granted");
  a_trans_sec_dom: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_l1_return ##0 (!l1_sec && !l1_pt && !ext_evt && !instr_r)
    |=> fs_code_r == FS_TRANS_SEC && fs_dom_r == $past(l1_desc[8:5]))
    else $error("section translation domain not from entry");
  a_page_perm: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_l2_return ##0 (l2_ok && dom_field == DOM_CLIENT && !perm_ok && !ext_evt && !instr_r)
    |=> abort_data && fs_code_r == FS_PERM_PAGE)
    else $error("sub-page permission fault missing");
  a_no_early_go: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == MFC_IDLE && acc_req && mmu_en |=> !acc_go [*2])
    else $error("access granted before checks");
  a_bus_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_evt |=> bus_stop == $past(b_restartable))
    else $error("bus stop does not match access class");
  a_lock_cancel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_evt && b_locked && b_class == BUS_UNCACHED_RD |=> lock_write_cancel)
    else $error("locked write not cancelled");
  a_fill_word0: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_evt && b_class == BUS_LINE_FILL && b_word == 2'h0 |=> fill_discard && !bus_stop)
    else $error("word zero fill abort mishandled");
  a_wb_nonrec: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_evt && b_class == BUS_BUF_WR |=> fs_nonrec_r && fs_code_r == FS_WRITE_BUF && !bus_stop)
    else $error("buffered write abort not non-recoverable");
endmodule

// [testbench/mfc_top_tb_top.sv]
// Self-checking bench for the fault checker: registers, access checks, external aborts.
// Assumes the descriptor model answers walks; the bench plays core and bus.
`timescale 1ns/1ps
module mfc_top_tb_top;
  import mfc_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, acc_req, acc_write, acc_byte, acc_instr, acc_user;
  logic l1_ready, l2_ready, acc_go, abort_data, abort_prefetch, ext_abort, bus_active;
  logic bus_page, bus_locked, bus_stop, lock_write_cancel, fill_discard, ext_abort_data;
  logic walk_go;
  logic [1:0] bus_word, dly;
  logic [2:0] bus_class;
  logic [3:0] bus_domain;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, acc_addr, l1_desc, l2_desc, bus_vaddr, d1_in, d2_in;
  logic [31:0] seed, exp_fsr, exp_far, r, a, dac, ctl;
  int err_count, n_tests, n;

  mfc_top mfc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_req(acc_req), .acc_addr(acc_addr), .acc_write(acc_write), .acc_byte(acc_byte),
    .acc_instr(acc_instr), .acc_user(acc_user), .l1_ready(l1_ready), .l1_desc(l1_desc),
    .l2_ready(l2_ready), .l2_desc(l2_desc), .acc_go(acc_go), .abort_data(abort_data),
    .abort_prefetch(abort_prefetch), .ext_abort(ext_abort), .bus_active(bus_active),
    .bus_class(bus_class), .bus_word(bus_word), .bus_page(bus_page),
    .bus_locked(bus_locked), .bus_domain(bus_domain), .bus_vaddr(bus_vaddr),
    .bus_stop(bus_stop), .lock_write_cancel(lock_write_cancel),
    .fill_discard(fill_discard), .ext_abort_data(ext_abort_data));
  mfc_walk_model mfc_walk_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .walk_go(walk_go),
    .dly(dly), .d1(d1_in), .d2(d2_in), .l1_ready(l1_ready), .l1_desc(l1_desc),
    .l2_ready(l2_ready), .l2_desc(l2_desc));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Returns {fault, domain, code}; fault low means the access may proceed.
  function automatic logic [8:0] exp_chk(logic [31:0] a, d1, d2, dac, ctl, logic [3:0] f);
    logic [3:0] dm;
    logic [1:0] fl, ap, q;
    logic pg, ok;
    dm = d1[8:5];
    fl = dac[2 * dm +: 2];
    pg = (d1[1:0] == L1_PAGE_TABLE);
    q = (d2[1:0] == L2_LARGE) ? a[15:14] : a[11:10];
    ap = pg ? d2[SUBPAGE_AP_LSB + 2 * q +: 2] : d1[SEC_AP_LSB +: 2];
    if (ctl[CTRL_ALIGN_BIT] && f[2:1] == 2'h0 && a[1:0] != 2'h0) return {5'h10, FS_ALIGN};
    if (!ctl[CTRL_MMU_EN_BIT]) return 9'h0;
    if (d1[1:0] == 2'h0 || d1[1:0] == 2'h3) return {1'b1, dm, FS_TRANS_SEC};
    if (pg && (d2[1:0] == 2'h0 || d2[1:0] == 2'h3)) return {1'b1, dm, FS_TRANS_PAGE};
    if (!fl[0]) return {1'b1, dm, pg ? FS_DOM_PAGE : FS_DOM_SEC};
    if (fl == DOM_MANAGER) return 9'h0;
    case (ap)
      2'h0: ok = ctl[CTRL_RDONLY_BIT] & !f[0] & !f[3];
      2'h1: ok = !f[0];
      2'h2: ok = !f[0] | !f[3];
      default: ok = 1'b1;
    endcase
    return ok ? 9'h0 : {1'b1, dm, pg ? FS_PERM_PAGE : FS_PERM_SEC};
  endfunction

  function automatic logic [3:0] bus_code(logic [2:0] c, logic p);
    case (c)
      BUS_UNCACHED_RD, BUS_UNBUF_WR: return p ? FS_BUS_PAGE : FS_BUS_SEC;
      BUS_L1_FETCH: return FS_WALK_L1;
      BUS_L2_FETCH: return FS_WALK_L2;
      BUS_LINE_FILL: return p ? FS_FILL_PAGE : FS_FILL_SEC;
      default: return FS_WRITE_BUF;
    endcase
  endfunction

  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] ad, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, e);
  endtask

  // Looks first in the cycle already under way: a verdict pulse stands for one cycle only.
  task automatic wait_out(input bit ext);
    int i;
    for (i = 0; i < 40; i++) begin
      #1;
      if (ext ? ext_abort_data === 1'b1 : (acc_go | abort_data | abort_prefetch) === 1'b1) break;
      @(posedge sys_clk);
    end
    if (i == 40) begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic check_acc(input logic [31:0] a, d1, d2, input logic [3:0] f);
    logic [8:0] e;
    e = exp_chk(a, d1, d2, dac, ctl, f);
    @(posedge sys_clk);
    acc_req <= 1'b1;
    acc_addr <= a;
    {acc_write, acc_byte, acc_instr, acc_user} <= f;
    walk_go <= ctl[CTRL_MMU_EN_BIT] && e[3:0] != FS_ALIGN;
    d1_in <= d1;
    d2_in <= d2;
    dly <= d2[31:30];
    @(posedge sys_clk);
    acc_req <= 1'b0;
    walk_go <= 1'b0;
    wait_out(0);
    chk("verdict", {acc_go, abort_data, abort_prefetch}, {!e[8], e[8] & !f[1], e[8] & f[1]});
    if (e[8] && !f[1]) begin
      exp_fsr = {24'h0, e[7:0]};
      exp_far = a;
    end
    chk_reg("fsr", OFF_FAULT_STATUS, exp_fsr);
    chk_reg("far", OFF_FAULT_ADDRESS, exp_far);
  endtask

  task automatic ext_ab(input logic [2:0] c, input logic p, w, lk);
    a = xs();
    @(posedge sys_clk);
    {bus_active, bus_class, bus_page, bus_word, bus_locked} <= {1'b1, c, p, 1'b0, w, lk};
    bus_domain <= a[7:4];
    bus_vaddr <= a;
    ext_abort <= 1'b1;
    @(posedge sys_clk);
    ext_abort <= 1'b0;
    wait_out(1);
    chk("stop", bus_stop, c < BUS_LINE_FILL);
    @(posedge sys_clk);
    #1 chk("discard", fill_discard, c == BUS_LINE_FILL && !w);
    chk("cancel", lock_write_cancel, lk);
    exp_fsr = {23'h0, c == BUS_BUF_WR, (c == BUS_L1_FETCH || c == BUS_BUF_WR) ? 4'h0 : a[7:4],
      bus_code(c, p)};
    exp_far = a;
    chk_reg("fsr", OFF_FAULT_STATUS, exp_fsr);
    chk_reg("far", OFF_FAULT_ADDRESS, exp_far);
    @(posedge sys_clk);
    bus_active <= 1'b0;
    bus_locked <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 chk("levels", {fill_discard, lock_write_cancel}, 2'h0);
  endtask

  initial begin
    {rst_n, reg_wr, reg_rd, acc_req, acc_write, acc_byte, acc_instr, acc_user} = 8'h0;
    {ext_abort, bus_active, bus_page, bus_locked, walk_go, dly, bus_word, bus_class} = 12'h0;
    {reg_addr, bus_domain, reg_wdata, acc_addr, bus_vaddr, d1_in, d2_in} = 172'h0;
    {seed, err_count, n_tests, exp_fsr, exp_far} = {32'h34, 128'h0};
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 5; n++) chk_reg("reset", 8'(4 * n), 32'h0);
    dac = xs();
    wr(OFF_DOMAIN_ACCESS, dac);
    wr(OFF_FAULT_STATUS, dac);
    chk_reg("dac", OFF_DOMAIN_ACCESS, dac);
    chk_reg("fsr ro", OFF_FAULT_STATUS, 32'h0);
    ctl = 32'h2;
    wr(OFF_CONTROL, ctl);
    // Unaligned word, byte and fetch with the MMU off: only the word faults.
    for (n = 0; n < 3; n++) check_acc(32'h1003, 32'h0, 32'h0, 4'(n * 2));
    for (n = 0; n < 120; n++) begin
      r = xs();
      dac = xs();
      ctl = {23'h0, r[8], 6'h0, r[1], 1'b1};
      wr(OFF_DOMAIN_ACCESS, dac);
      wr(OFF_CONTROL, ctl);
      a = xs() & {30'h3fffffff, {2{r[3]}}};
      check_acc(a, xs(), xs(), r[7:4]);
    end
    // Line fill aborted on word 0, then on word 1 against the system's advice.
    // one abort per bus class, with a word-one fill abort last
    for (n = 0; n < 7; n++) ext_ab(n > 5 ? BUS_LINE_FILL : 3'(n), 1'(xs()), n == 6, n == 0);
    print_verdict();
  end
endmodule

// [testbench/mfc_walk_model.sv]
// Descriptor memory model: answers level-one and level-two fetches after a set delay.
// Assumes the bench pulses walk_go in the cycle that the access request is offered.
`timescale 1ns/1ps
module mfc_walk_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Walk control
  input wire logic walk_go,
  input wire logic [1:0] dly,
  input wire logic [31:0] d1,
  input wire logic [31:0] d2,
  // Descriptor returns
  output logic l1_ready,
  output logic [31:0] l1_desc,
  output logic l2_ready,
  output logic [31:0] l2_desc
);
  import mfc_pkg::*;
  logic [2:0] cnt_r;
  logic ph_r;
  // Released descriptor lines toggle, so a stale word never passes for a fresh one.
  always_ff @(posedge sys_clk) begin
    l1_ready <= 1'b0;
    l2_ready <= 1'b0;
    l1_desc <= ~l1_desc;
    l2_desc <= ~l2_desc;
    if (!rst_n) begin
      cnt_r <= 3'h0;
      ph_r <= 1'b0;
      l1_desc <= 32'h0;
      l2_desc <= 32'h0;
    end else if (walk_go) begin
      cnt_r <= {1'b0, dly} + 3'h1;
      ph_r <= 1'b0;
    end else if (cnt_r == 3'h1 && !ph_r) begin
      l1_ready <= 1'b1;
      l1_desc <= d1;
      cnt_r <= (d1[1:0] == L1_PAGE_TABLE) ? {1'b0, dly} + 3'h1 : 3'h0;
      ph_r <= 1'b1;
    end else if (cnt_r == 3'h1) begin
      l2_ready <= 1'b1;
      l2_desc <= d2;
      cnt_r <= 3'h0;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
endmodule
